// ### hw/mrx_rx_ctl.sv
// mrx_rx_ctl: receive path control (enable, preamble and delimiter checks, forced
// realignment) with tx oversize / abort statistics, an APB register file and an irq
// assumes all inputs are synchronous to pclk and come from logic in the same domain
`timescale 1ns/1ps
module mrx_rx_ctl #(
    parameter int LOCK_CNT = mrx_pkg::LOCK_CNT_DEF,
    parameter int RST_CYC = mrx_pkg::RST_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mrx_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_beat_valid,
    input wire logic tx_beat_eop,
    input wire logic tx_beat_err,
    input wire logic [mrx_pkg::BYTES_W-1:0] tx_beat_bytes,
    input wire logic rx_in_valid,
    input wire logic rx_in_hdr_ok,
    input wire logic rx_in_start,
    input wire logic rx_in_term,
    input wire logic rx_in_err,
    input wire logic [63:0] rx_in_data,
    output logic rx_out_valid,
    output logic rx_out_sop,
    output logic rx_out_eop,
    output logic rx_out_err,
    output logic [63:0] rx_out_data,
    output logic stat_rx_packet,
    output logic stat_rx_bad_preamble,
    output logic stat_rx_bad_sfd,
    output logic stat_tx_oversize,
    output logic stat_tx_abort,
    output logic irq
);
    function automatic logic hit(
        input logic [mrx_pkg::ADDR_W-1:0] a,
        input logic [mrx_pkg::ADDR_W-1:0] off
    );
        hit = (a == off);
    endfunction : hit

    mrx_txst_if txst ();

    // register file state
    logic en_r, en_nxt;
    logic chk_pre_r, chk_pre_nxt;
    logic chk_sfd_r, chk_sfd_nxt;
    logic [mrx_pkg::INT_W-1:0] int_stat_r, int_stat_nxt;
    logic [mrx_pkg::INT_W-1:0] int_en_r, int_en_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic wr;
    logic resync_req;
    logic [mrx_pkg::INT_W-1:0] clr;
    logic [mrx_pkg::INT_W-1:0] ev;

    // alignment state
    mrx_pkg::mrx_al_t al_st_r, al_st_nxt;
    logic [mrx_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic lock_ev_r, lock_ev_nxt;
    logic locked;

    // receive frame state
    mrx_pkg::mrx_rx_t rx_st_r, rx_st_nxt;
    logic first_r, first_nxt;
    logic herr_r, herr_nxt;
    logic eacc_r, eacc_nxt;
    logic ov_r, ov_nxt;
    logic osop_r, osop_nxt;
    logic oeop_r, oeop_nxt;
    logic oerr_r, oerr_nxt;
    logic [63:0] odata_r, odata_nxt;
    logic pkt_r, pkt_nxt;
    logic bpre_r, bpre_nxt;
    logic bsfd_r, bsfd_nxt;
    logic start_ok;

    // tx statistics
    assign txst.beat_valid = tx_beat_valid;
    assign txst.beat_eop = tx_beat_eop;
    assign txst.beat_err = tx_beat_err;
    assign txst.beat_bytes = tx_beat_bytes;

    mrx_tx_stat u_tx_stat (
        .pclk(pclk),
        .presetn(presetn),
        .st(txst.stat)
    );

    assign stat_tx_oversize = txst.oversize;
    assign stat_tx_abort = txst.abort;

    // apb slave: zero wait states, read data captured in the setup cycle
    assign pready = 1'h1;
    assign wr = psel && penable && pwrite;
    assign resync_req = wr && hit(paddr, mrx_pkg::ADDR_CTRL)
        && pwdata[mrx_pkg::CTRL_RESYNC_BIT];
    assign clr = (wr && hit(paddr, mrx_pkg::ADDR_INT_CLR)) ? pwdata[mrx_pkg::INT_W-1:0] : '0;
    assign locked = (al_st_r == mrx_pkg::AL_LOCKED);

    always_comb
    begin
        ev = '0;
        ev[mrx_pkg::EV_TX_LARGE] = txst.oversize;
        ev[mrx_pkg::EV_TX_ABORT] = txst.abort;
        ev[mrx_pkg::EV_RX_PRE] = bpre_r;
        ev[mrx_pkg::EV_RX_SFD] = bsfd_r;
        ev[mrx_pkg::EV_LOCK] = lock_ev_r;
    end

    always_comb
    begin
        en_nxt = en_r;
        chk_pre_nxt = chk_pre_r;
        chk_sfd_nxt = chk_sfd_r;
        int_en_nxt = int_en_r;
        if (wr && hit(paddr, mrx_pkg::ADDR_CTRL))
        begin
            en_nxt = pwdata[mrx_pkg::CTRL_EN_BIT];
            chk_pre_nxt = pwdata[mrx_pkg::CTRL_PRE_BIT];
            chk_sfd_nxt = pwdata[mrx_pkg::CTRL_SFD_BIT];
        end
        if (wr && hit(paddr, mrx_pkg::ADDR_INT_EN))
            int_en_nxt = pwdata[mrx_pkg::INT_W-1:0];
        // a new event wins over a clear in the same cycle
        int_stat_nxt = (int_stat_r & ~clr) | ev;
        irq_nxt = |(int_stat_nxt & int_en_nxt);
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'h0;
        if (psel && !penable)
        begin
            prdata_nxt = '0;
            if (hit(paddr, mrx_pkg::ADDR_CTRL))
            begin
                prdata_nxt[mrx_pkg::CTRL_EN_BIT] = en_r;
                prdata_nxt[mrx_pkg::CTRL_PRE_BIT] = chk_pre_r;
                prdata_nxt[mrx_pkg::CTRL_SFD_BIT] = chk_sfd_r;
            end
            else if (hit(paddr, mrx_pkg::ADDR_STAT))
            begin
                prdata_nxt[mrx_pkg::STAT_ACTIVE_BIT] = en_r || rx_st_r == mrx_pkg::RX_FRAME;
                prdata_nxt[mrx_pkg::STAT_FRAME_BIT] = rx_st_r == mrx_pkg::RX_FRAME;
                prdata_nxt[mrx_pkg::STAT_LOCK_BIT] = locked;
                prdata_nxt[mrx_pkg::STAT_REALIGN_BIT] = al_st_r == mrx_pkg::AL_RESET;
            end
            else if (hit(paddr, mrx_pkg::ADDR_INT_STAT))
                prdata_nxt[mrx_pkg::INT_W-1:0] = int_stat_r;
            else if (hit(paddr, mrx_pkg::ADDR_INT_EN))
                prdata_nxt[mrx_pkg::INT_W-1:0] = int_en_r;
            else if (!hit(paddr, mrx_pkg::ADDR_INT_CLR))
                pslverr_nxt = 1'h1;
        end
        else if (psel)
            pslverr_nxt = pslverr_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= mrx_pkg::CTRL_EN_RST;
            chk_pre_r <= 1'h0;
            chk_sfd_r <= 1'h0;
            int_stat_r <= '0;
            int_en_r <= '0;
            irq_r <= 1'h0;
            prdata_r <= '0;
            pslverr_r <= 1'h0;
        end
        else
        begin
            en_r <= en_nxt;
            chk_pre_r <= chk_pre_nxt;
            chk_sfd_r <= chk_sfd_nxt;
            int_stat_r <= int_stat_nxt;
            int_en_r <= int_en_nxt;
            irq_r <= irq_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    // alignment: hunt for LOCK_CNT good block headers from reset; a resync first holds in AL_RESET for RST_CYC cycles
    always_comb
    begin
        al_st_nxt = al_st_r;
        cnt_nxt = cnt_r;
        lock_ev_nxt = 1'h0;
        if (resync_req)
        begin
            al_st_nxt = mrx_pkg::AL_RESET;
            cnt_nxt = '0;
        end
        else
        begin
            case (al_st_r)
                mrx_pkg::AL_RESET:
                begin
                    if (cnt_r == mrx_pkg::CNT_W'(RST_CYC - 1))
                    begin
                        al_st_nxt = mrx_pkg::AL_HUNT;
                        cnt_nxt = '0;
                    end
                    else
                        cnt_nxt = cnt_r + 1'h1;
                end
                mrx_pkg::AL_HUNT:
                begin
                    if (rx_in_valid && rx_in_hdr_ok)
                    begin
                        if (cnt_r == mrx_pkg::CNT_W'(LOCK_CNT - 1))
                        begin
                            al_st_nxt = mrx_pkg::AL_LOCKED;
                            cnt_nxt = '0;
                            lock_ev_nxt = 1'h1;
                        end
                        else
                            cnt_nxt = cnt_r + 1'h1;
                    end
                    else if (rx_in_valid)
                        cnt_nxt = '0;
                end
                mrx_pkg::AL_LOCKED:
                begin
                    if (rx_in_valid && !rx_in_hdr_ok)
                    begin
                        al_st_nxt = mrx_pkg::AL_HUNT;
                        cnt_nxt = '0;
                    end
                end
                default:
                begin
                    al_st_nxt = mrx_pkg::AL_HUNT;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            al_st_r <= mrx_pkg::AL_HUNT;
            cnt_r <= '0;
            lock_ev_r <= 1'h0;
        end
        else
        begin
            al_st_r <= al_st_nxt;
            cnt_r <= cnt_nxt;
            lock_ev_r <= lock_ev_nxt;
        end
    end

    // frames start only while enabled; one already running is finished unless a resync or loss of lock cuts it short
    assign start_ok = en_r && locked && !resync_req && rx_in_valid && rx_in_start;

    always_comb
    begin
        rx_st_nxt = rx_st_r;
        first_nxt = first_r;
        herr_nxt = herr_r;
        eacc_nxt = eacc_r;
        ov_nxt = 1'h0;
        osop_nxt = 1'h0;
        oeop_nxt = 1'h0;
        oerr_nxt = 1'h0;
        odata_nxt = odata_r;
        pkt_nxt = 1'h0;
        bpre_nxt = 1'h0;
        bsfd_nxt = 1'h0;
        case (rx_st_r)
            mrx_pkg::RX_IDLE:
            begin
                if (start_ok)
                begin
                    rx_st_nxt = mrx_pkg::RX_FRAME;
                    first_nxt = 1'h1;
                    eacc_nxt = 1'h0;
                    bpre_nxt = chk_pre_r
                        && rx_in_data[mrx_pkg::PRE_W-1:0] != mrx_pkg::PREAMBLE;
                    bsfd_nxt = chk_sfd_r
                        && rx_in_data[63:mrx_pkg::PRE_W] != mrx_pkg::SFD;
                    herr_nxt = bpre_nxt || bsfd_nxt;
                end
            end
            mrx_pkg::RX_FRAME:
            begin
                if (resync_req || !locked)
                begin
                    // cut the frame short; close it only if a beat already left
                    rx_st_nxt = mrx_pkg::RX_IDLE;
                    if (!first_r)
                    begin
                        ov_nxt = 1'h1;
                        oeop_nxt = 1'h1;
                        oerr_nxt = 1'h1;
                        odata_nxt = '0;
                    end
                end
                else if (rx_in_valid)
                begin
                    ov_nxt = 1'h1;
                    osop_nxt = first_r;
                    first_nxt = 1'h0;
                    odata_nxt = rx_in_data;
                    if (rx_in_term)
                    begin
                        oeop_nxt = 1'h1;
                        oerr_nxt = herr_r || eacc_r || rx_in_err;
                        pkt_nxt = 1'h1;
                        rx_st_nxt = mrx_pkg::RX_IDLE;
                    end
                    else
                        eacc_nxt = eacc_r || rx_in_err;
                end
            end
            default:
                rx_st_nxt = mrx_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_r <= mrx_pkg::RX_IDLE;
            first_r <= 1'h0;
            herr_r <= 1'h0;
            eacc_r <= 1'h0;
            ov_r <= 1'h0;
            osop_r <= 1'h0;
            oeop_r <= 1'h0;
            oerr_r <= 1'h0;
            odata_r <= '0;
            pkt_r <= 1'h0;
            bpre_r <= 1'h0;
            bsfd_r <= 1'h0;
        end
        else
        begin
            rx_st_r <= rx_st_nxt;
            first_r <= first_nxt;
            herr_r <= herr_nxt;
            eacc_r <= eacc_nxt;
            ov_r <= ov_nxt;
            osop_r <= osop_nxt;
            oeop_r <= oeop_nxt;
            oerr_r <= oerr_nxt;
            odata_r <= odata_nxt;
            pkt_r <= pkt_nxt;
            bpre_r <= bpre_nxt;
            bsfd_r <= bsfd_nxt;
        end
    end

    assign rx_out_valid = ov_r;
    assign rx_out_sop = osop_r;
    assign rx_out_eop = oeop_r;
    assign rx_out_err = oerr_r;
    assign rx_out_data = odata_r;
    assign stat_rx_packet = pkt_r;
    assign stat_rx_bad_preamble = bpre_r;
    assign stat_rx_bad_sfd = bsfd_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_in_reset;
        al_st_r == mrx_pkg::AL_RESET && cnt_r == '0;
    endsequence
    sequence s_reset_done;
        al_st_r == mrx_pkg::AL_RESET && cnt_r == mrx_pkg::CNT_W'(RST_CYC - 1) && !resync_req;
    endsequence
    sequence s_hunt_fresh;
        al_st_r == mrx_pkg::AL_HUNT && cnt_r == '0;
    endsequence

    a_no_start_off: assert property (rx_st_r == mrx_pkg::RX_IDLE && !en_r |=> rx_st_r == mrx_pkg::RX_IDLE)
        else $error("frame started while receive is disabled");
    a_frame_finish: assert property (rx_st_r == mrx_pkg::RX_FRAME && !en_r && locked && !resync_req && rx_in_valid && !rx_in_term |=> rx_st_r == mrx_pkg::RX_FRAME)
        else $error("running frame dropped on disable");
    a_off_quiet: assert property (rx_st_r == mrx_pkg::RX_IDLE && !en_r |=> !rx_out_valid && !stat_rx_packet && !stat_rx_bad_preamble && !stat_rx_bad_sfd)
        else $error("receive activity while disabled");
    a_pre_check: assert property (rx_st_r == mrx_pkg::RX_IDLE && start_ok |=> stat_rx_bad_preamble == $past(chk_pre_r && rx_in_data[mrx_pkg::PRE_W-1:0] != mrx_pkg::PREAMBLE))
        else $error("preamble check result wrong");
    a_sfd_check: assert property (rx_st_r == mrx_pkg::RX_IDLE && start_ok |=> stat_rx_bad_sfd == $past(chk_sfd_r && rx_in_data[63:mrx_pkg::PRE_W] != mrx_pkg::SFD))
        else $error("delimiter check result wrong");
    a_resync_entry: assert property (resync_req |=> s_in_reset ##0 rx_st_r == mrx_pkg::RX_IDLE)
        else $error("resync did not reset the receive path");
    a_realign_step: assert property (s_reset_done |=> s_hunt_fresh)
        else $error("receive path did not leave reset to realign");
    a_rx_pkt_pulse: assert property (stat_rx_packet |=> !stat_rx_packet)
        else $error("receive packet statistic longer than one cycle");
    a_int_set_wins: assert property (ev != '0 |=> (int_stat_r & $past(ev)) == $past(ev))
        else $error("interrupt event lost");
    a_irq_level: assert property (irq == |(int_stat_r & int_en_r))
        else $error("irq does not follow enabled status");
endmodule : mrx_rx_ctl

// ### hw/mrx_pkg.sv
// mrx_pkg: constants, register map and state types of the rx control / tx stats block
// assumes one pclk domain and an APB register port with 8-bit byte addresses
package mrx_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_BYTES = 8;
    localparam int BYTES_W = 4;
    localparam int LEN_W = 16;
    localparam int CNT_W = 16;
    localparam int PRE_W = 56;
    localparam int SFD_W = 8;
    // largest length counted as a standard packet, 9215 bytes
    localparam logic [LEN_W-1:0] MAX_STD_LEN = 16'h23FF;
    localparam logic [PRE_W-1:0] PREAMBLE = 56'h55555555555555;
    localparam logic [SFD_W-1:0] SFD = 8'hD5;
    localparam int LOCK_CNT_DEF = 64;
    localparam int RST_CYC_DEF = 4;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_CLR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN = 8'h10;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PRE_BIT = 1;
    localparam int CTRL_SFD_BIT = 2;
    localparam int CTRL_RESYNC_BIT = 3;
    localparam logic CTRL_EN_RST = 1'h1;

    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_FRAME_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_REALIGN_BIT = 3;

    localparam int INT_W = 5;
    localparam int EV_TX_LARGE = 0;
    localparam int EV_TX_ABORT = 1;
    localparam int EV_RX_PRE = 2;
    localparam int EV_RX_SFD = 3;
    localparam int EV_LOCK = 4;

    typedef enum logic [1:0] {AL_RESET, AL_HUNT, AL_LOCKED} mrx_al_t;
    typedef enum logic {RX_IDLE, RX_FRAME} mrx_rx_t;
endpackage : mrx_pkg

// ### hw/mrx_txst_if.sv
// mrx_txst_if: transmit beat summary from the top to the tx statistics unit
// assumes both ends run on pclk
`timescale 1ns/1ps
interface mrx_txst_if;
    logic beat_valid;
    logic beat_eop;
    logic beat_err;
    logic [mrx_pkg::BYTES_W-1:0] beat_bytes;
    logic oversize;
    logic abort;
    modport mac (output beat_valid, beat_eop, beat_err, beat_bytes, input oversize, abort);
    modport stat (input beat_valid, beat_eop, beat_err, beat_bytes, output oversize, abort);
endinterface : mrx_txst_if

// ### hw/mrx_tx_stat.sv
// mrx_tx_stat: per-packet byte count and the oversize / abort increment pulses
// assumes beats arrive on pclk with a byte count of 1 to DATA_BYTES
`timescale 1ns/1ps
module mrx_tx_stat (
    input wire logic pclk,
    input wire logic presetn,
    mrx_txst_if.stat st
);
    logic [mrx_pkg::LEN_W-1:0] len_r, len_nxt;
    logic [mrx_pkg::LEN_W:0] sum;
    logic large_r, large_nxt;
    logic abort_r, abort_nxt;

    always_comb
    begin
        sum = {1'h0, len_r} + {{(mrx_pkg::LEN_W + 1 - mrx_pkg::BYTES_W){1'h0}}, st.beat_bytes};
        len_nxt = len_r;
        large_nxt = 1'h0;
        abort_nxt = 1'h0;
        if (st.beat_valid)
        begin
            if (st.beat_eop)
            begin
                len_nxt = '0;
                large_nxt = sum > {1'h0, mrx_pkg::MAX_STD_LEN};
                abort_nxt = st.beat_err;
            end
            else if (sum[mrx_pkg::LEN_W])
                len_nxt = '1;
            else
                len_nxt = sum[mrx_pkg::LEN_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_r <= '0;
            large_r <= 1'h0;
            abort_r <= 1'h0;
        end
        else
        begin
            len_r <= len_nxt;
            large_r <= large_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign st.oversize = large_r;
    assign st.abort = abort_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_large_cnt: assert property ((st.beat_valid && st.beat_eop) |=> st.oversize == $past(sum > {1'h0, mrx_pkg::MAX_STD_LEN}))
        else $error("oversize pulse does not match packet length");
    a_tx_abort_eop: assert property ((st.beat_valid && st.beat_eop && st.beat_err) |=> st.abort)
        else $error("abort at end of packet not counted");
    a_tx_stat_pulse: assert property (!(st.beat_valid && st.beat_eop) |=> !st.oversize && !st.abort)
        else $error("tx statistic pulse without end of packet");
endmodule : mrx_tx_stat

// ### test/mrx_fab_model.sv
// mrx_fab_model: user fabric that counts the statistic pulses and receive beats
// assumes every pulse is synchronous to pclk; one count per asserted cycle
`timescale 1ns/1ps
module mrx_fab_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [8:0] pulses,
    output logic [8:0][15:0] cnt
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= '0;
        end
        else
        begin
            for (int i = 0; i < 9; i++)
            begin
                if (pulses[i] === 1'b1)
                begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end
            end
        end
    end
endmodule : mrx_fab_model

// ### test/mrx_rx_ctl_test.sv
// mrx_rx_ctl_test: apb, tx beat and rx block drivers with counted statistics
// assumes pready answers on its own; counts come from the fabric model
`timescale 1ns/1ps
module mrx_rx_ctl_test;
    localparam int LOCKS = 4;
    localparam int RSTC = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdq;
    logic pready, pslverr, perr, irq;
    logic tx_beat_valid = 1'b0, tx_beat_eop = 1'b0, tx_beat_err = 1'b0;
    logic [3:0] tx_beat_bytes = 4'h0;
    logic rx_in_valid = 1'b0, rx_in_hdr_ok = 1'b0, rx_in_start = 1'b0;
    logic rx_in_term = 1'b0, rx_in_err = 1'b0;
    logic [63:0] rx_in_data = 64'h0;
    logic rx_out_valid, stat_rx_packet, stat_rx_bad_preamble, stat_rx_bad_sfd;
    logic rx_out_sop, rx_out_eop, rx_out_err;
    logic [63:0] rx_out_data;
    logic [63:0] last_d = 64'h0;
    logic stat_tx_oversize, stat_tx_abort;
    logic [8:0][15:0] cnt, snap;
    int n_fail = 0, compares = 0, cyc = 0;

    always #2 pclk = ~pclk;

    mrx_rx_ctl #(.LOCK_CNT(LOCKS), .RST_CYC(RSTC)) u_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .tx_beat_valid, .tx_beat_eop, .tx_beat_err, .tx_beat_bytes,
        .rx_in_valid, .rx_in_hdr_ok, .rx_in_start, .rx_in_term, .rx_in_err, .rx_in_data,
        .rx_out_valid, .rx_out_sop, .rx_out_eop, .rx_out_err, .rx_out_data,
        .stat_rx_packet, .stat_rx_bad_preamble, .stat_rx_bad_sfd, .stat_tx_oversize,
        .stat_tx_abort, .irq
    );

    mrx_fab_model u_fab (
        .pclk, .presetn, .cnt,
        .pulses({rx_out_err, rx_out_eop, rx_out_sop, rx_out_valid, stat_tx_abort,
            stat_tx_oversize, stat_rx_bad_sfd, stat_rx_bad_preamble, stat_rx_packet})
    );

    // keeps the last forwarded receive word for data checks
    always @(posedge pclk)
        if (rx_out_valid === 1'b1)
            last_d <= rx_out_data;

    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] cv(input int i);
        return {16'h0000, cnt[i]};
    endfunction : cv

    function automatic logic [31:0] sv(input int i, input int n);
        return {16'h0000, snap[i] + 16'(n)};
    endfunction : sv

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdq = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdq & m, e);
    endtask : rd

    task automatic tx_pkt(input int n, input logic err);
        int left;
        left = n;
        snap = cnt;
        while (left > 0)
        begin
            @(posedge pclk);
            tx_beat_valid <= 1'b1;
            tx_beat_bytes <= (left > 8) ? 4'h8 : left[3:0];
            tx_beat_eop <= (left <= 8);
            tx_beat_err <= err && (left <= 8);
            left -= 8;
        end
        @(posedge pclk);
        tx_beat_valid <= 1'b0;
        tx_beat_eop <= 1'b0;
        tx_beat_err <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : tx_pkt

    task automatic rx_beat(input logic st, input logic term, input logic [63:0] d);
        @(posedge pclk);
        rx_in_valid <= 1'b1;
        rx_in_hdr_ok <= 1'b1;
        rx_in_start <= st;
        rx_in_term <= term;
        rx_in_data <= d;
    endtask : rx_beat

    task automatic rx_off();
        @(posedge pclk);
        rx_in_valid <= 1'b0;
        rx_in_start <= 1'b0;
        rx_in_term <= 1'b0;
        rx_in_data <= ~rx_in_data;
        repeat (4) @(posedge pclk);
    endtask : rx_off

    task automatic rx_frame(input logic [55:0] pre, input logic [7:0] sfd, input int n);
        rx_beat(1'b1, 1'b0, {sfd, pre});
        for (int i = 0; i < n; i++)
            rx_beat(1'b0, i == n - 1, 64'hA5A5_0000_0000_0000 + 64'(i));
        rx_off();
    endtask : rx_frame

    task automatic relock();
        repeat (LOCKS) rx_beat(1'b0, 1'b0, 64'h1E);
        rx_off();
    endtask : relock

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(mrx_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
        rd(mrx_pkg::ADDR_INT_EN, 32'hFFFFFFFF, 32'h0);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, perr}, 32'h1);
        apb(1'b1, mrx_pkg::ADDR_INT_EN, 32'h1F);
        tx_pkt(9215, 1'b0);
        chk(cv(3), sv(3, 0));
        tx_pkt(9216, 1'b0);
        chk(cv(3), sv(3, 1));
        chk({31'h0, irq}, 32'h1);
        rd(mrx_pkg::ADDR_INT_STAT, 32'hFFFFFFFF, 32'h1);
        apb(1'b1, mrx_pkg::ADDR_INT_CLR, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        tx_pkt(16, 1'b1);
        chk(cv(4), sv(4, 1));
        apb(1'b1, mrx_pkg::ADDR_INT_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(mrx_pkg::ADDR_INT_STAT, 32'h3, 32'h2);
        relock();
        rd(mrx_pkg::ADDR_STAT, 32'h4, 32'h4);
        apb(1'b1, mrx_pkg::ADDR_CTRL, 32'h7);
        snap = cnt;
        rx_frame(mrx_pkg::PREAMBLE, mrx_pkg::SFD, 3);
        chk(cv(0), sv(0, 1));
        chk(cv(5), sv(5, 3));
        chk(cv(1), sv(1, 0));
        chk(cv(6), sv(6, 1));
        chk(cv(8), sv(8, 0));
        chk(last_d[63:32], 32'hA5A50000);
        chk(last_d[31:0], 32'h00000002);
        rx_frame(56'h0, mrx_pkg::SFD, 2);
        chk(cv(1), sv(1, 1));
        chk(cv(2), sv(2, 0));
        chk(cv(8), sv(8, 1));
        rx_frame(mrx_pkg::PREAMBLE, 8'h00, 2);
        chk(cv(2), sv(2, 1));
        chk(cv(8), sv(8, 2));
        apb(1'b1, mrx_pkg::ADDR_CTRL, 32'h1);
        snap = cnt;
        rx_frame(56'h0, 8'h00, 2);
        chk(cv(1), sv(1, 0));
        chk(cv(2), sv(2, 0));
        chk(cv(8), sv(8, 0));
        snap = cnt;
        fork
            rx_frame(mrx_pkg::PREAMBLE, mrx_pkg::SFD, 6);
            begin
                repeat (3) @(posedge pclk);
                apb(1'b1, mrx_pkg::ADDR_CTRL, 32'h6);
            end
        join
        chk(cv(5), sv(5, 6));
        chk(cv(7), sv(7, 1));
        chk(last_d[31:0], 32'h00000005);
        rd(mrx_pkg::ADDR_STAT, 32'h3, 32'h0);
        snap = cnt;
        rx_frame(56'h0, 8'h00, 3);
        for (int i = 0; i < 9; i++)
            chk(cv(i), sv(i, 0));
        apb(1'b1, mrx_pkg::ADDR_CTRL, 32'h9);
        rd(mrx_pkg::ADDR_STAT, 32'h4, 32'h0);
        repeat (RSTC + 2) @(posedge pclk);
        relock();
        rd(mrx_pkg::ADDR_STAT, 32'h4, 32'h4);
        give_verdict();
    end
endmodule : mrx_rx_ctl_test
